/* caf_accept_filter.v */
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "caf_consts.vh"

// Functional notes
// - Sixteen filters, each with its own standard and extended compare values.
// - Three masks, each may serve several filters.
// - Included standard identifier bits must equal the filter's stored bits.
// - Included extended bits (upper two, lower sixteen) must equal stored bits.
// - Frame-type enable set: filter select bit chooses extended or standard only.
// - Frame-type enable clear: select bit ignored, either format may match.
// - Mask standard bit one includes the position, zero makes it don't-care.
// - Mask upper extended bits include when set, don't-care when clear.
// - Two-bit mask selector per filter: 00, 01, 10 pick masks zero to two.
// - Selectors packed two bits per filter in two 16-bit words.
// - Bits 4 and 2 of standard words ignore writes and read zero.
// - Only enabled filters can hit.
// - Four-bit destination per filter: 1111 means FIFO, else buffer number.
// - Masks also hold sixteen lower extended include bits.
module caf_accept_filter (
  input  wire        ref_clk_in,
  input  wire        resetn_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  input  wire        msg_valid_in,
  input  wire [10:0] msg_std_in,
  input  wire [17:0] msg_ext_in,
  input  wire        msg_is_ext_in,
  output reg         result_valid_out,
  output reg         hit_any_out,
  output reg  [15:0] hit_vec_out,
  output reg  [3:0]  hit_index_out,
  output reg  [3:0]  dest_ptr_out,
  output reg         dest_fifo_out
);

  // ========================================================================
  // Configuration storage
  // ========================================================================
  reg  [15:0] filt_std_r [0:15];
  reg  [15:0] filt_ext_r [0:15];
  reg  [15:0] mask_std_r [0:2];
  reg  [15:0] mask_ext_r [0:2];
  reg  [15:0] dest_r     [0:3];
  reg  [15:0] msksel_lo_r;
  reg  [15:0] msksel_hi_r;
  reg  [15:0] flt_en_r;
  reg  [15:0] acc_cnt_r;
  reg  [15:0] acc_cnt_nxt;

  wire [31:0] msksel_all;
  wire [15:0] hit_w;
  wire        any_w;
  wire [3:0]  index_w;
  wire [15:0] dest_word_w;
  wire [3:0]  dest_w;

  // ========================================================================
  // APB decode
  // ========================================================================
  wire        acc_phase;
  wire        wr_en;
  wire [5:0]  region;
  wire [3:0]  slot;
  wire [15:0] wdata;
  wire [15:0] wdata_std;
  reg  [15:0] rd_word;
  reg         rd_ok;
  wire [15:0] result_word;
  wire        rd_err;
  wire [31:0] rd_data;
  integer     i;
  integer     j;
  integer     k;

  // ========================================================================
  // Address regions of the two filter word arrays
  // ========================================================================
  localparam [11:0] FILT_STD_BASE = `CAF_ADDR_FILT_STD_BASE;
  localparam [11:0] FILT_EXT_BASE = `CAF_ADDR_FILT_EXT_BASE;
  localparam [5:0]  STD_REGION    = FILT_STD_BASE[11:6];
  localparam [5:0]  EXT_REGION    = FILT_EXT_BASE[11:6];

  assign acc_phase = psel_in & penable_in;
  assign wr_en     = acc_phase & pwrite_in & pready_out;
  assign region    = paddr_in[11:6];
  assign slot      = paddr_in[5:2];
  assign wdata     = pwdata_in[15:0];
  assign wdata_std = wdata & `CAF_STD_WR_MASK;

  // Result fields as software sees them
  assign result_word = {6'h00, dest_fifo_out, hit_any_out, dest_ptr_out, hit_index_out};

  // ========================================================================
  // Write strobes, each taken only at the edge that completes the access
  // ========================================================================
  wire        wr_aligned;
  wire        wr_filt_std;
  wire        wr_filt_ext;
  wire        wr_cnt_clr;

  assign wr_aligned  = wr_en & (paddr_in[1:0] == 2'b00);
  assign wr_filt_std = wr_aligned & (region == STD_REGION);
  assign wr_filt_ext = wr_aligned & (region == EXT_REGION);
  assign wr_cnt_clr  = wr_en & (paddr_in == `CAF_ADDR_ACC_CNT);

  // Read mux and map check
  always @* begin
    rd_word = 16'h0000;
    rd_ok   = 1'b1;
    if (paddr_in[1:0] != 2'b00) begin
      rd_ok = 1'b0;
    end else if (region == STD_REGION) begin
      rd_word = filt_std_r[slot];
    end else if (region == EXT_REGION) begin
      rd_word = filt_ext_r[slot];
    end else begin
      case (paddr_in)
        `CAF_ADDR_MSKSEL_LO: rd_word = msksel_lo_r;
        `CAF_ADDR_MSKSEL_HI: rd_word = msksel_hi_r;
        `CAF_ADDR_FLT_EN:    rd_word = flt_en_r;
        `CAF_ADDR_MASK_STD0: rd_word = mask_std_r[0];
        `CAF_ADDR_MASK_STD1: rd_word = mask_std_r[1];
        `CAF_ADDR_MASK_STD2: rd_word = mask_std_r[2];
        `CAF_ADDR_MASK_EXT0: rd_word = mask_ext_r[0];
        `CAF_ADDR_MASK_EXT1: rd_word = mask_ext_r[1];
        `CAF_ADDR_MASK_EXT2: rd_word = mask_ext_r[2];
        `CAF_ADDR_DEST0:     rd_word = dest_r[0];
        `CAF_ADDR_DEST1:     rd_word = dest_r[1];
        `CAF_ADDR_DEST2:     rd_word = dest_r[2];
        `CAF_ADDR_DEST3:     rd_word = dest_r[3];
        `CAF_ADDR_HIT_VEC:   rd_word = hit_vec_out;
        `CAF_ADDR_RESULT:    rd_word = result_word;
        `CAF_ADDR_ACC_CNT:   rd_word = acc_cnt_r;
        default:             rd_ok   = 1'b0;
      endcase
    end
  end

  // ========================================================================
  // APB answer: one wait state, data and error from flops
  // ========================================================================
  assign rd_err  = ~rd_ok;
  assign rd_data = (pwrite_in || rd_err) ? 32'h0000_0000 : {16'h0000, rd_word};

  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      // Only the first access edge answers, so pready stays a one-cycle pulse
      if (acc_phase && !pready_out) begin
        pready_out  <= 1'b1;
        pslverr_out <= rd_err;
        prdata_out  <= rd_data;
      end else begin
        pready_out  <= 1'b0;
        pslverr_out <= 1'b0;
        prdata_out  <= 32'h0000_0000;
      end
    end
  end

  // ========================================================================
  // Filter words
  // ========================================================================
  // Bits 4 and 2 of a standard word are dropped on the way in
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (i = 0; i < 16; i = i + 1) begin
        filt_std_r[i] <= `CAF_RST_IDENT;
      end
    end else if (wr_filt_std) begin
      filt_std_r[slot] <= wdata_std;
    end
  end

  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (j = 0; j < 16; j = j + 1) begin
        filt_ext_r[j] <= `CAF_RST_IDENT;
      end
    end else if (wr_filt_ext) begin
      filt_ext_r[slot] <= wdata;
    end
  end

  // ========================================================================
  // Masks, selectors, enables, destinations
  // ========================================================================
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (k = 0; k < 3; k = k + 1) begin
        mask_std_r[k] <= `CAF_RST_IDENT;
        mask_ext_r[k] <= `CAF_RST_IDENT;
      end
      for (k = 0; k < 4; k = k + 1) begin
        dest_r[k] <= `CAF_RST_DEST;
      end
      msksel_lo_r <= `CAF_RST_MSKSEL;
      msksel_hi_r <= `CAF_RST_MSKSEL;
      flt_en_r    <= `CAF_RST_FLT_EN;
    end else if (wr_en) begin
      case (paddr_in)
        `CAF_ADDR_MSKSEL_LO: msksel_lo_r   <= wdata;
        `CAF_ADDR_MSKSEL_HI: msksel_hi_r   <= wdata;
        `CAF_ADDR_FLT_EN:    flt_en_r      <= wdata;
        `CAF_ADDR_MASK_STD0: mask_std_r[0] <= wdata_std;
        `CAF_ADDR_MASK_STD1: mask_std_r[1] <= wdata_std;
        `CAF_ADDR_MASK_STD2: mask_std_r[2] <= wdata_std;
        `CAF_ADDR_MASK_EXT0: mask_ext_r[0] <= wdata;
        `CAF_ADDR_MASK_EXT1: mask_ext_r[1] <= wdata;
        `CAF_ADDR_MASK_EXT2: mask_ext_r[2] <= wdata;
        `CAF_ADDR_DEST0:     dest_r[0]     <= wdata;
        `CAF_ADDR_DEST1:     dest_r[1]     <= wdata;
        `CAF_ADDR_DEST2:     dest_r[2]     <= wdata;
        `CAF_ADDR_DEST3:     dest_r[3]     <= wdata;
        default: begin
        end
      endcase
    end
  end

  // ========================================================================
  // Per-filter compare
  // ========================================================================
  assign msksel_all = {msksel_hi_r, msksel_lo_r};

  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_filt
      wire [1:0]  sel;
      reg  [15:0] m_std;
      reg  [15:0] m_ext;
      reg         m_ok;

      assign sel = msksel_all[2*g+1:2*g];

      // Code 11 has no mask behind it, so such a filter never hits
      always @* begin
        m_std = mask_std_r[0];
        m_ext = mask_ext_r[0];
        m_ok  = 1'b1;
        case (sel)
          `CAF_MSK_SEL_M0: begin
            m_std = mask_std_r[0];
            m_ext = mask_ext_r[0];
          end
          `CAF_MSK_SEL_M1: begin
            m_std = mask_std_r[1];
            m_ext = mask_ext_r[1];
          end
          `CAF_MSK_SEL_M2: begin
            m_std = mask_std_r[2];
            m_ext = mask_ext_r[2];
          end
          default: begin
            m_ok = 1'b0;
          end
        endcase
      end

      caf_ident_cmp u_cmp (
        .filt_std_in   (filt_std_r[g]),
        .filt_ext_in   (filt_ext_r[g]),
        .mask_std_in   (m_std),
        .mask_ext_in   (m_ext),
        .mask_valid_in (m_ok),
        .enable_in     (flt_en_r[g]),
        .msg_std_in    (msg_std_in),
        .msg_ext_in    (msg_ext_in),
        .msg_is_ext_in (msg_is_ext_in),
        .hit_out       (hit_w[g])
      );
    end
  endgenerate

  // Index of the lowest hitting filter
  caf_lowest_hit u_enc (
    .hits_in   (hit_w),
    .any_out   (any_w),
    .index_out (index_w)
  );

  // Four pointers per word: filter 4k+j sits in nibble j of word k
  assign dest_word_w = dest_r[index_w[3:2]];
  assign dest_w      = dest_word_w[{index_w[1:0], 2'b00} +: 4];

  // ========================================================================
  // Result stage
  // ========================================================================
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      result_valid_out <= 1'b0;
      hit_any_out      <= 1'b0;
      hit_vec_out      <= 16'h0000;
      hit_index_out    <= 4'h0;
      dest_ptr_out     <= 4'h0;
      dest_fifo_out    <= 1'b0;
    end else begin
      result_valid_out <= msg_valid_in;
      if (msg_valid_in) begin
        hit_any_out   <= any_w;
        hit_vec_out   <= hit_w;
        hit_index_out <= index_w;
        // A miss names no buffer, so a stale pointer is never used
        dest_ptr_out  <= any_w ? dest_w : 4'h0;
        dest_fifo_out <= any_w & (dest_w == `CAF_FIFO_DEST);
      end
    end
  end

  // ========================================================================
  // Accepted message counter, write clears, a hit in the same cycle wins
  // ========================================================================
  always @* begin
    acc_cnt_nxt = acc_cnt_r;
    // Clear first, then count, so a hit in the clearing cycle is kept
    if (wr_cnt_clr) begin
      acc_cnt_nxt = 16'h0000;
    end
    if (msg_valid_in && any_w) begin
      acc_cnt_nxt = acc_cnt_nxt + 16'h0001;
    end
  end

  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc_cnt_r <= `CAF_RST_CNT;
    end else begin
      acc_cnt_r <= acc_cnt_nxt;
    end
  end

endmodule // caf_accept_filter
`default_nettype wire

/* caf_accept_filter_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "caf_consts.vh"
module caf_accept_filter_bench;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, mv, mx, rv, hany, dfifo;
  logic [10:0] mstd;
  logic [17:0] mext;
  logic [15:0] hvec, en;
  logic [3:0]  hidx, dptr;
  logic [15:0] fs [16], fe [16], ks [3], ke [3];
  logic [1:0]  fsel [16];
  logic [3:0]  dp [16];
  int          err_total = 0;
  int          check_count = 0;
  int          cyc = 0;
  always #25 clk = ~clk;
  caf_can_engine u_eng (.clk_in(clk), .msg_valid_out(mv), .msg_std_out(mstd),
    .msg_ext_out(mext), .msg_is_ext_out(mx));
  caf_accept_filter dut (.ref_clk_in(clk), .resetn_in(resetn), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .msg_valid_in(mv),
    .msg_std_in(mstd), .msg_ext_in(mext), .msg_is_ext_in(mx), .result_valid_out(rv),
    .hit_any_out(hany), .hit_vec_out(hvec), .hit_index_out(hidx), .dest_ptr_out(dptr),
    .dest_fifo_out(dfifo));
  // ========
  // Shared tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n >= 20, 0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 16'h0000, r, e);
    chk(r, x);
    chk(e, xe);
  endtask
  task automatic set_f(input int n, input logic [15:0] s, input logic [15:0] x,
                       input logic [1:0] sel, input logic [3:0] dst);
    logic [15:0] lo, hi, dw;
    fs[n] = s & 16'hFFEB;
    fe[n] = x;
    fsel[n] = sel;
    dp[n] = dst;
    for (int i = 0; i < 8; i++) {hi[2*i+:2], lo[2*i+:2]} = {fsel[i+8], fsel[i]};
    for (int i = 0; i < 4; i++) dw[4*i+:4] = dp[n/4*4+i];
    wr(`CAF_ADDR_FILT_STD_BASE + 12'(4*n), s);
    wr(`CAF_ADDR_FILT_EXT_BASE + 12'(4*n), x);
    wr(`CAF_ADDR_MSKSEL_LO, lo);
    wr(`CAF_ADDR_MSKSEL_HI, hi);
    wr(`CAF_ADDR_DEST0 + 12'(n/4*4), dw);
  endtask
  task automatic set_m(input int k, input logic [15:0] s, input logic [15:0] x);
    ks[k] = s & 16'hFFEB;
    ke[k] = x;
    wr(`CAF_ADDR_MASK_STD0 + 12'(4*k), s);
    wr(`CAF_ADDR_MASK_EXT0 + 12'(4*k), x);
  endtask
  task automatic set_en(input logic [15:0] v);
    en = v;
    wr(`CAF_ADDR_FLT_EN, v);
  endtask
  function automatic logic [15:0] ref_vec(logic [10:0] s, logic [17:0] x, logic e);
    logic [15:0] v, m;
    v = 16'h0000;
    for (int i = 0; i < 16; i++) if (fsel[i] != 2'b11 && en[i]) begin
      m = ks[fsel[i]];
      v[i] = !(m[3] && fs[i][3] != e) && ((s ^ fs[i][15:5]) & m[15:5]) == 11'h000 &&
        (!e || (({fs[i][1:0], fe[i]} ^ x) & {m[1:0], ke[fsel[i]]}) == 18'h0_0000);
    end
    return v;
  endfunction
  task automatic msg(input logic [10:0] s, input logic [17:0] x, input logic e);
    logic [15:0] v;
    logic [3:0]  ix;
    v = ref_vec(s, x, e);
    ix = 4'h0;
    for (int i = 15; i >= 0; i--) if (v[i]) ix = 4'(i);
    u_eng.send(s, x, e);
    #1;
    chk(rv, 1);
    chk(hvec, v);
    chk(hidx, ix);
    chk(hany, v != 0);
    chk(dptr, v != 0 ? dp[ix] : 4'h0);
    chk(dfifo, v != 0 && dp[ix] == 4'hF);
  endtask
  // ========
  // Scenarios
  task automatic t_reset();
    rd_chk(`CAF_ADDR_MSKSEL_LO, 32'h0000_0000, 1'b0);
    rd_chk(`CAF_ADDR_MSKSEL_HI, 32'h0000_0000, 1'b0);
    rd_chk(`CAF_ADDR_FLT_EN, 32'h0000_FFFF, 1'b0);
    rd_chk(`CAF_ADDR_DEST3, 32'h0000_0000, 1'b0);
    rd_chk(12'h0CC, 32'h0000_0000, 1'b1);
    rd_chk(12'h082, 32'h0000_0000, 1'b1);
    msg(11'h123, 18'h0_0000, 1'b0);
    rd_chk(`CAF_ADDR_HIT_VEC, 32'h0000_FFFF, 1'b0);
    rd_chk(`CAF_ADDR_RESULT, 32'h0000_0100, 1'b0);
    rd_chk(`CAF_ADDR_ACC_CNT, 32'h0000_0001, 1'b0);
    wr(`CAF_ADDR_ACC_CNT, 16'hFFFF);
    rd_chk(`CAF_ADDR_ACC_CNT, 32'h0000_0000, 1'b0);
    $display("reset test done");
  endtask
  task automatic t_unimpl();
    set_f(3, 16'hFFFF, 16'hFFFF, 2'b00, 4'h0);
    rd_chk(`CAF_ADDR_FILT_STD_BASE + 12'h00C, 32'h0000_FFEB, 1'b0);
    rd_chk(`CAF_ADDR_FILT_EXT_BASE + 12'h00C, 32'h0000_FFFF, 1'b0);
    set_m(1, 16'hFFFF, 16'hFFFF);
    rd_chk(`CAF_ADDR_MASK_STD1, 32'h0000_FFEB, 1'b0);
    $display("unimplemented bits test done");
  endtask
  task automatic t_std();
    set_en(16'h7FFE);
    set_m(0, 16'hFFE0, 16'h0000);
    set_m(1, 16'hFF00, 16'h0000);
    set_m(2, 16'h0000, 16'h0000);
    for (int f = 0; f < 16; f++)
      set_f(f, {11'(11'h400 + 9 * f), 5'h00}, 16'h0000, f == 14 ? 2'b10 : {1'b0, f[0]},
            4'(f + 1));
    for (int f = 0; f < 16; f++) begin
      msg(11'(11'h400 + 9 * f), 18'h0_0000, 1'b0);
      msg(11'(11'h401 + 9 * f), 18'h0_0000, 1'b0);
    end
    set_en(16'h3FFE);
    msg(11'h400, 18'h0_0000, 1'b0);
    msg(11'h41B, 18'h0_0000, 1'b0);
    $display("standard identifier test done");
  endtask
  task automatic t_frame();
    set_en(16'h000F);
    set_m(0, 16'hFFE8, 16'h0000);
    set_m(1, 16'hFFE0, 16'h0000);
    for (int f = 0; f < 4; f++)
      set_f(f, {11'h2A5, 1'b0, ~f[0], 3'h0}, 16'h1234, {1'b0, f[1]}, 4'hF);
    msg(11'h2A5, 18'h0_1234, 1'b0);
    msg(11'h2A5, 18'h0_1234, 1'b1);
    $display("frame type test done");
  endtask
  task automatic t_ext();
    set_en(16'h0003);
    set_m(2, 16'h0003, 16'hFFFF);
    set_f(0, 16'h0002, 16'hA5C3, 2'b10, 4'hF);
    set_f(1, 16'h0001, 16'h0000, 2'b10, 4'h2);
    msg(11'h000, 18'h2_A5C3, 1'b1);
    msg(11'h000, 18'h2_A5C2, 1'b1);
    msg(11'h000, 18'h1_0000, 1'b1);
    msg(11'h005, 18'h3_FFFF, 1'b0);
    set_m(2, 16'h0000, 16'h00FF);
    msg(11'h000, 18'h3_FFC3, 1'b1);
    rd_chk(`CAF_ADDR_RESULT, 32'h0000_03F0, 1'b0);
    $display("extended identifier test done");
  endtask
  initial begin
    for (int i = 0; i < 16; i++) {fs[i], fe[i], fsel[i], dp[i]} = '0;
    for (int i = 0; i < 3; i++) {ks[i], ke[i]} = '0;
    en = 16'hFFFF;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_unimpl();
    t_std();
    t_frame();
    t_ext();
    complete_run();
  end
endmodule // caf_accept_filter_bench
`default_nettype wire

/* caf_accept_filter_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module caf_accept_filter_monitor (
  input wire logic        ref_clk_in,
  input wire logic        resetn_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        msg_valid_in,
  input wire logic        result_valid_out,
  input wire logic        hit_any_out,
  input wire logic [15:0] hit_vec_out,
  input wire logic [3:0]  hit_index_out,
  input wire logic [3:0]  dest_ptr_out,
  input wire logic        dest_fifo_out
);
  // ========
  // Port relations
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  wire std_word = (paddr_in < 12'h040) || (paddr_in >= 12'h090 && paddr_in <= 12'h098);
  result_latency_a:
    assert property (1'b1 |=> result_valid_out == $past(msg_valid_in))
    else $error("result strobe not one cycle after message");
  result_hold_a:
    assert property (!result_valid_out |-> $stable(hit_vec_out) && $stable(hit_index_out))
    else $error("result changed without a message");
  any_vector_a:
    assert property (hit_any_out == (hit_vec_out != 16'h0000))
    else $error("hit flag disagrees with hit vector");
  index_hit_a:
    assert property (hit_any_out |-> hit_vec_out[hit_index_out])
    else $error("reported filter did not hit");
  lowest_index_a:
    assert property ((hit_vec_out & ((16'h0001 << hit_index_out) - 16'h0001)) == 16'h0000)
    else $error("a lower filter also hit");
  fifo_flag_a:
    assert property (dest_fifo_out == (hit_any_out && dest_ptr_out == 4'hF))
    else $error("fifo flag wrong");
  miss_zero_a:
    assert property (!hit_any_out |-> dest_ptr_out == 4'h0 && hit_index_out == 4'h0)
    else $error("miss left pointer or index set");
  unimpl_zero_a:
    assert property (pready_out && !pwrite_in && std_word |-> !prdata_out[4] && !prdata_out[2])
    else $error("unimplemented bit read as one");
  ready_wait_a:
    assert property (psel_in && !penable_in |=> !pready_out ##1 pready_out)
    else $error("bus answer not after one wait state");
endmodule // caf_accept_filter_monitor
bind caf_accept_filter caf_accept_filter_monitor u_monitor (.*);
`default_nettype wire

/* caf_can_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module caf_can_engine (
  input  wire logic        clk_in,
  output var  logic        msg_valid_out,
  output var  logic [10:0] msg_std_out,
  output var  logic [17:0] msg_ext_out,
  output var  logic        msg_is_ext_out
);
  // ========
  // Identifier strobe
  initial begin
    msg_valid_out = 1'b0;
    msg_std_out = 11'h000;
    msg_ext_out = 18'h0_0000;
    msg_is_ext_out = 1'b0;
  end
  // Idle lines show the inverse so a stale identifier is never trusted
  task automatic send(input logic [10:0] s, input logic [17:0] x, input logic e);
    @(posedge clk_in);
    msg_valid_out <= 1'b1;
    msg_std_out <= s;
    msg_ext_out <= x;
    msg_is_ext_out <= e;
    @(posedge clk_in);
    msg_valid_out <= 1'b0;
    msg_std_out <= ~s;
    msg_ext_out <= ~x;
    msg_is_ext_out <= ~e;
  endtask
endmodule // caf_can_engine
`default_nettype wire

/* caf_consts.vh */
`ifndef CAF_CONSTS_VH
`define CAF_CONSTS_VH

// ==========================================================================
// Register byte addresses
// ==========================================================================
`define CAF_ADDR_FILT_STD_BASE 12'h000
`define CAF_ADDR_FILT_EXT_BASE 12'h040
`define CAF_ADDR_MSKSEL_LO     12'h080
`define CAF_ADDR_MSKSEL_HI     12'h084
`define CAF_ADDR_FLT_EN        12'h088
`define CAF_ADDR_MASK_STD0     12'h090
`define CAF_ADDR_MASK_STD1     12'h094
`define CAF_ADDR_MASK_STD2     12'h098
`define CAF_ADDR_MASK_EXT0     12'h0A0
`define CAF_ADDR_MASK_EXT1     12'h0A4
`define CAF_ADDR_MASK_EXT2     12'h0A8
`define CAF_ADDR_DEST0         12'h0B0
`define CAF_ADDR_DEST1         12'h0B4
`define CAF_ADDR_DEST2         12'h0B8
`define CAF_ADDR_DEST3         12'h0BC
`define CAF_ADDR_HIT_VEC       12'h0C0
`define CAF_ADDR_RESULT        12'h0C4
`define CAF_ADDR_ACC_CNT       12'h0C8

// ==========================================================================
// Field positions
// ==========================================================================
`define CAF_STD_ID_HI    15
`define CAF_STD_ID_LO    5
`define CAF_FRAME_BIT    3
`define CAF_EXT_UP_HI    1
`define CAF_EXT_UP_LO    0
`define CAF_STD_WR_MASK  16'hFFEB
`define CAF_FIFO_DEST    4'hF
`define CAF_MSK_SEL_M0   2'b00
`define CAF_MSK_SEL_M1   2'b01
`define CAF_MSK_SEL_M2   2'b10

// ==========================================================================
// Reset values
// ==========================================================================
`define CAF_RST_IDENT    16'h0000
`define CAF_RST_MSKSEL   16'h0000
`define CAF_RST_FLT_EN   16'hFFFF
`define CAF_RST_DEST     16'h0000
`define CAF_RST_CNT      16'h0000

`endif

/* caf_ident_cmp.v */
`timescale 1ns/1ps
`default_nettype none
`include "caf_consts.vh"

module caf_ident_cmp (
  input  wire [15:0] filt_std_in,
  input  wire [15:0] filt_ext_in,
  input  wire [15:0] mask_std_in,
  input  wire [15:0] mask_ext_in,
  input  wire        mask_valid_in,
  input  wire        enable_in,
  input  wire [10:0] msg_std_in,
  input  wire [17:0] msg_ext_in,
  input  wire        msg_is_ext_in,
  output wire        hit_out
);
  wire [10:0] std_diff;
  wire [17:0] ext_diff;
  wire        std_ok;
  wire        ext_ok;
  wire        frame_ok;

  // ========================================================================
  // Masked compare
  // ========================================================================
  assign std_diff = (filt_std_in[`CAF_STD_ID_HI:`CAF_STD_ID_LO] ^ msg_std_in)
                    & mask_std_in[`CAF_STD_ID_HI:`CAF_STD_ID_LO];
  assign ext_diff = ({filt_std_in[`CAF_EXT_UP_HI:`CAF_EXT_UP_LO], filt_ext_in} ^ msg_ext_in)
                    & {mask_std_in[`CAF_EXT_UP_HI:`CAF_EXT_UP_LO], mask_ext_in};
  assign std_ok   = (std_diff == 11'h000);
  // Standard frames carry no extension, so only the base part is compared
  assign ext_ok   = ~msg_is_ext_in | (ext_diff == 18'h0_0000);
  assign frame_ok = ~mask_std_in[`CAF_FRAME_BIT] |
                    (msg_is_ext_in == filt_std_in[`CAF_FRAME_BIT]);
  assign hit_out  = enable_in & mask_valid_in & std_ok & ext_ok & frame_ok;

endmodule // caf_ident_cmp
`default_nettype wire

/* caf_lowest_hit.v */
`timescale 1ns/1ps
`default_nettype none

module caf_lowest_hit (
  input  wire [15:0] hits_in,
  output reg         any_out,
  output reg  [3:0]  index_out
);
  integer i;

  // ========================================================================
  // Lowest set bit wins
  // ========================================================================
  always @* begin
    any_out   = 1'b0;
    index_out = 4'h0;
    for (i = 15; i >= 0; i = i - 1) begin
      if (hits_in[i]) begin
        any_out   = 1'b1;
        index_out = i[3:0];
      end
    end
  end

endmodule // caf_lowest_hit
`default_nettype wire
